//--- verilog/rtpc_pkg.sv
package rtpc_pkg;

  // register byte offsets
  localparam logic [7:0] RTPC_OFS_CTL0 = 8'h00;
  localparam logic [7:0] RTPC_OFS_CTL1 = 8'h04;
  localparam logic [7:0] RTPC_OFS_CTL2 = 8'h08;
  localparam logic [7:0] RTPC_OFS_CNTH = 8'h0C;
  localparam logic [7:0] RTPC_OFS_CNTL = 8'h10;
  localparam logic [7:0] RTPC_OFS_RLDH = 8'h14;
  localparam logic [7:0] RTPC_OFS_RLDL = 8'h18;
  localparam logic [7:0] RTPC_OFS_MATH = 8'h1C;
  localparam logic [7:0] RTPC_OFS_MATL = 8'h20;

  // field positions
  localparam int RTPC_BIT_MODE_MSB = 7;
  localparam int RTPC_LSB_CAUSE = 5;
  localparam int RTPC_LSB_DLY = 1;
  localparam int RTPC_BIT_CAPFLAG = 0;
  localparam int RTPC_BIT_EN = 7;
  localparam int RTPC_BIT_POL = 6;
  localparam int RTPC_LSB_EXP = 3;
  localparam int RTPC_LSB_MODE = 0;
  localparam int RTPC_BIT_BUF = 6;
  localparam int RTPC_BIT_DUAL = 5;
  localparam int RTPC_BIT_CLKSRC = 0;

  // values after reset and special counts
  localparam logic [7:0] RTPC_CTL_RST = 8'h00;
  localparam logic [15:0] RTPC_CNT_RST = 16'h0001;
  localparam logic [15:0] RTPC_RLD_RST = 16'hFFFF;
  localparam logic [15:0] RTPC_MAT_RST = 16'h0000;
  localparam logic [15:0] RTPC_CNT_RESTART = 16'h0001;
  localparam logic [15:0] RTPC_CNT_WRAP = 16'h0000;
  localparam logic [15:0] RTPC_CNT_TOP = 16'hFFFF;

  // operating modes
  localparam logic [3:0] RTPC_M_ONESHOT = 4'h0;
  localparam logic [3:0] RTPC_M_CONT = 4'h1;
  localparam logic [3:0] RTPC_M_COUNTER = 4'h2;
  localparam logic [3:0] RTPC_M_PWM1 = 4'h3;
  localparam logic [3:0] RTPC_M_CAP = 4'h4;
  localparam logic [3:0] RTPC_M_CMP = 4'h5;
  localparam logic [3:0] RTPC_M_GATED = 4'h6;
  localparam logic [3:0] RTPC_M_CAPCMP = 4'h7;
  localparam logic [3:0] RTPC_M_PWM2 = 4'h8;
  localparam logic [3:0] RTPC_M_CAPRST = 4'h9;
  localparam logic [3:0] RTPC_M_CMPCNT = 4'hA;

  // interrupt cause codes (bits 6:5 of control zero)
  localparam logic [1:0] RTPC_CAUSE_ALL = 2'h0;
  localparam logic [1:0] RTPC_CAUSE_DEASSERT = 2'h2;
  localparam logic [1:0] RTPC_CAUSE_RLD_CMP = 2'h3;

  typedef struct packed {
    logic en;
    logic pol;
    logic [2:0] exponent;
    logic [3:0] mode;
    logic [1:0] cause;
    logic [2:0] dly;
    logic buf_en;
    logic dual_edge;
    logic clk_src;
  } rtpc_ctl_t;

endpackage : rtpc_pkg

//--- verilog/rtpc_sync.sv
`timescale 1ns/1ns
module rtpc_sync import rtpc_pkg::*; #(
  parameter int W = 2
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // asynchronous inputs
  input wire logic [W-1:0] din,
  // synchronised level and edges
  output logic [W-1:0] lvl,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);

  for (genvar i = 0; i < W; i++) begin : g_bit
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        s1_reg <= 1'b0;
        s2_reg <= 1'b0;
        s3_reg <= 1'b0;
      end else begin
        s1_reg <= din[i];
        s2_reg <= s1_reg;
        s3_reg <= s2_reg;
      end
    end
    assign lvl[i] = s2_reg;
    assign rise[i] = s2_reg & ~s3_reg;
    assign fall[i] = ~s2_reg & s3_reg;
  end

endmodule : rtpc_sync

//--- verilog/rtpc_prescaler.sv
`timescale 1ns/1ns
module rtpc_prescaler import rtpc_pkg::*; #(
  parameter int EXP_W = 3
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // control
  input wire logic clear,
  input wire logic step,
  input wire logic [EXP_W-1:0] exponent,
  // divided tick
  output logic tick
);

  localparam int DIV_W = (1 << EXP_W) - 1;

  logic [DIV_W-1:0] div_reg;
  logic [DIV_W-1:0] mask;
  logic wrap;

  assign mask = DIV_W'((32'd1 << exponent) - 32'd1); // [R2]
  assign wrap = step && ((div_reg & mask) == mask);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_reg <= '0;
      tick <= 1'b0;
    end else if (clear) begin
      div_reg <= '0; // [R3]
      tick <= 1'b0;
    end else begin
      tick <= wrap;
      if (step) begin
        div_reg <= wrap ? '0 : div_reg + 1'b1;
      end
    end
  end

  property p_div_clear;
    @(posedge hclk) disable iff (!hresetn)
    clear |=> (div_reg == '0) && !tick;
  endproperty
  a_div_clear: assert property (p_div_clear) else $error("divider not cleared"); // [R3]

endmodule : rtpc_prescaler

//--- verilog/rtpc_timer.sv
// The placing of the registers and the AHB-Lite register port were left to the implementer.
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// [R1] 16-bit up-counter, software reads/writes two bytes
// [R2] count clock divided by 2**exponent
// [R3] prescaler divider cleared while timer disabled
// [R4] input pin slower than quarter system clock
// [R5] reaching reload value restarts count at 0001h
// [R6] compare mode uses reload bytes as compare
// [R7] match equals count toggles PWM output
// [R8] capture stores count into match register
// [R9] read-only flag: last interrupt from capture; the code also sets it on gated-mode gate and deassert interrupts
// [R10] dual PWM delays active drive by programmed cycles
// [R11] four-bit mode decode, eleven modes
// [R12] control one bit 7 starts/stops timer
// [R13] control one bit 6 sets pin polarity
// [R14] match writes immediate or buffered until reload
// [R15] dual-edge bit counts/captures both input edges
// [R16] clock-source bit picks system or peripheral clock
// [R17] cause field filters which events interrupt
// [R18] software writes zero to reserved bits
// [R19] count past FFFFh wraps to 0000h
// [R20] one-shot clears enable after reload interrupt
// [R21] counter mode counts pin edges, no prescaler
// [R22] count advances per tick, holds while disabled
////////////////////////////////////////////////////////////////////////////////
module rtpc_timer import rtpc_pkg::*; (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // timer pins
  input wire logic timer_in,
  input wire logic periph_clk,
  output logic timer_out,
  output logic timer_out_n,
  output logic timer_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [7:0] ctl0_reg;
  logic [7:0] ctl1_reg;
  logic [7:0] ctl2_reg;
  logic cap_flag_reg;
  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;
  logic [15:0] rld_reg;
  logic [15:0] mat_reg;
  logic [15:0] mat_next;
  logic [15:0] mat_buf_reg;
  logic mat_pend_reg;
  logic lvl_reg;
  logic lvl_next;
  logic [2:0] dly_cnt_reg;
  logic dp_wr_reg;
  logic [7:0] dp_addr_reg;
  rtpc_ctl_t ctl;
  default clocking cb_main @(posedge hclk); endclocking
  default disable iff (!hresetn);

  ////////////////////////////////////////////////////////////////////////////
  // bus decode
  wire ap = hsel && htrans[1] && hready;
  wire ap_ok = (haddr[31:8] == 24'h000000);
  wire [7:0] wdata = hwdata[7:0];
  wire wr_ctl0 = dp_wr_reg && (dp_addr_reg == RTPC_OFS_CTL0);
  wire wr_ctl1 = dp_wr_reg && (dp_addr_reg == RTPC_OFS_CTL1);
  wire wr_ctl2 = dp_wr_reg && (dp_addr_reg == RTPC_OFS_CTL2);
  wire wr_cnth = dp_wr_reg && (dp_addr_reg == RTPC_OFS_CNTH);
  wire wr_cntl = dp_wr_reg && (dp_addr_reg == RTPC_OFS_CNTL);
  wire wr_rldh = dp_wr_reg && (dp_addr_reg == RTPC_OFS_RLDH);
  wire wr_rldl = dp_wr_reg && (dp_addr_reg == RTPC_OFS_RLDL);
  wire wr_math = dp_wr_reg && (dp_addr_reg == RTPC_OFS_MATH);
  wire wr_matl = dp_wr_reg && (dp_addr_reg == RTPC_OFS_MATL);
  wire sw_cnt_wr = wr_cnth || wr_cntl;
  // reserved bits read as zero
  wire [7:0] ctl0_rd = {ctl0_reg[7:5], 1'b0, ctl0_reg[3:1], cap_flag_reg};
  wire [7:0] rd_byte =
    (haddr[7:0] == RTPC_OFS_CTL0) ? ctl0_rd :
    (haddr[7:0] == RTPC_OFS_CTL1) ? ctl1_reg :
    (haddr[7:0] == RTPC_OFS_CTL2) ? ctl2_reg :
    (haddr[7:0] == RTPC_OFS_CNTH) ? cnt_reg[15:8] : // [R1]
    (haddr[7:0] == RTPC_OFS_CNTL) ? cnt_reg[7:0] :
    (haddr[7:0] == RTPC_OFS_RLDH) ? rld_reg[15:8] :
    (haddr[7:0] == RTPC_OFS_RLDL) ? rld_reg[7:0] :
    (haddr[7:0] == RTPC_OFS_MATH) ? mat_reg[15:8] :
    (haddr[7:0] == RTPC_OFS_MATL) ? mat_reg[7:0] : 8'h00;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr_reg <= 1'b0;
      dp_addr_reg <= 8'h00;
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      dp_wr_reg <= ap && hwrite && ap_ok;
      dp_addr_reg <= haddr[7:0];
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (ap && !hwrite) begin
        hrdata <= {24'h000000, ap_ok ? rd_byte : 8'h00};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control field decode
  assign ctl = '{
    en: ctl1_reg[RTPC_BIT_EN], // [R12]
    pol: ctl1_reg[RTPC_BIT_POL], // [R13]
    exponent: ctl1_reg[RTPC_LSB_EXP +: 3],
    mode: {ctl0_reg[RTPC_BIT_MODE_MSB], ctl1_reg[RTPC_LSB_MODE +: 3]}, // [R11]
    cause: ctl0_reg[RTPC_LSB_CAUSE +: 2],
    dly: ctl0_reg[RTPC_LSB_DLY +: 3],
    buf_en: ctl2_reg[RTPC_BIT_BUF],
    dual_edge: ctl2_reg[RTPC_BIT_DUAL],
    clk_src: ctl2_reg[RTPC_BIT_CLKSRC]
  };

  wire m_oneshot = (ctl.mode == RTPC_M_ONESHOT); // [R11]
  wire m_counter = (ctl.mode == RTPC_M_COUNTER);
  wire m_pwm1 = (ctl.mode == RTPC_M_PWM1);
  wire m_cap = (ctl.mode == RTPC_M_CAP);
  wire m_cmp = (ctl.mode == RTPC_M_CMP);
  wire m_gated = (ctl.mode == RTPC_M_GATED);
  wire m_capcmp = (ctl.mode == RTPC_M_CAPCMP);
  wire m_pwm2 = (ctl.mode == RTPC_M_PWM2);
  wire m_caprst = (ctl.mode == RTPC_M_CAPRST);
  wire m_cmpcnt = (ctl.mode == RTPC_M_CMPCNT);
  wire is_pwm = m_pwm1 || m_pwm2;
  wire is_pin_cnt = m_counter || m_cmpcnt;
  wire is_capture = m_cap || m_capcmp || m_caprst;

  ////////////////////////////////////////////////////////////////////////////
  // input pins and count tick
  logic [1:0] pin_lvl;
  logic [1:0] pin_rise;
  logic [1:0] pin_fall;
  logic pre_tick;

  // bit 0 timer input, bit 1 peripheral clock
  rtpc_sync #(.W(2)) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .din({periph_clk, timer_in}),
    .lvl(pin_lvl),
    .rise(pin_rise),
    .fall(pin_fall)
  );

  wire pin_edge = ctl.dual_edge ? (pin_rise[0] || pin_fall[0]) : // [R15]
    (ctl.pol ? pin_fall[0] : pin_rise[0]); // [R13]
  wire in_active = pin_lvl[0] ^ ctl.pol;
  wire in_deassert = ctl.pol ? pin_rise[0] : pin_fall[0];
  wire pre_step = ctl.en && (ctl.clk_src ? pin_rise[1] : 1'b1); // [R16]

  rtpc_prescaler #(.EXP_W(3)) u_pre (
    .hclk(hclk),
    .hresetn(hresetn),
    .clear(!ctl.en), // [R3]
    .step(pre_step),
    .exponent(ctl.exponent), // [R2]
    .tick(pre_tick)
  );

  // pin-count modes bypass the prescaler; gated counts only while active
  wire count_tick = ctl.en && (is_pin_cnt ? pin_edge : // [R21]
    (m_gated ? (pre_tick && in_active) : pre_tick)); // [R22]

  ////////////////////////////////////////////////////////////////////////////
  // events
  wire reload_hit = count_tick && (cnt_reg == rld_reg); // [R5]
  wire rld_evt = reload_hit && !m_cmp;
  wire cmp_evt = reload_hit && m_cmp; // [R6]
  wire match_hit = count_tick && is_pwm && (cnt_reg == mat_reg); // [R7]
  wire cap_evt = ctl.en && is_capture && pin_edge; // [R8]
  wire cap_restart = cap_evt && (m_caprst || m_capcmp);
  wire gate_evt = ctl.en && m_gated && in_deassert;
  wire deassert_evt = ctl.en && (is_capture || m_gated) && in_deassert;
  wire in_evt = cap_evt || gate_evt;
  wire irq_fire = (ctl.cause == RTPC_CAUSE_RLD_CMP) ? (rld_evt || cmp_evt) : // [R17]
    (ctl.cause == RTPC_CAUSE_DEASSERT) ? deassert_evt :
    (rld_evt || cmp_evt || in_evt);
  wire irq_from_input = (ctl.cause == RTPC_CAUSE_DEASSERT) ? 1'b1 : // [R9]
    (ctl.cause == RTPC_CAUSE_RLD_CMP) ? 1'b0 : in_evt;
  wire oneshot_done = rld_evt && m_oneshot;
  wire mat_apply = mat_pend_reg && (rld_evt || cmp_evt || !ctl.en);

  ////////////////////////////////////////////////////////////////////////////
  // next count and match values
  always_comb begin
    cnt_next = cnt_reg;
    if (sw_cnt_wr) begin
      if (wr_cnth) cnt_next[15:8] = wdata; // [R1]
      if (wr_cntl) cnt_next[7:0] = wdata;
    end else if (cap_restart || rld_evt) begin
      cnt_next = RTPC_CNT_RESTART; // [R5]
    end else if (count_tick) begin
      cnt_next = cnt_reg + 16'h0001; // [R19] [R22]
    end
  end
  always_comb begin
    mat_next = mat_reg;
    if (cap_evt) begin
      mat_next = cnt_reg; // [R8]
    end else if (!ctl.buf_en && (wr_math || wr_matl)) begin
      if (wr_math) mat_next[15:8] = wdata; // [R14]
      if (wr_matl) mat_next[7:0] = wdata;
    end else if (mat_apply) begin
      mat_next = mat_buf_reg; // [R14]
    end
  end
  always_comb begin
    lvl_next = lvl_reg;
    if (!ctl.en) begin
      lvl_next = ctl.pol;
    end else if (is_pwm && reload_hit) begin
      lvl_next = ctl.pol;
    end else if (match_hit) begin
      lvl_next = ~lvl_reg; // [R7]
    end else if (!is_pwm && (rld_evt || cmp_evt)) begin
      lvl_next = ~lvl_reg;
    end
  end

  wire lvl_chg = (lvl_next != lvl_reg);
  wire dead = m_pwm2 && (dly_cnt_reg != 3'h0); // [R10]

  ////////////////////////////////////////////////////////////////////////////
  // state registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctl0_reg <= RTPC_CTL_RST;
      ctl1_reg <= RTPC_CTL_RST;
      ctl2_reg <= RTPC_CTL_RST;
    end else begin
      // reserved bits are not stored
      if (wr_ctl0) ctl0_reg <= {wdata[7:5], 1'b0, wdata[3:1], 1'b0};
      if (wr_ctl1) ctl1_reg <= wdata;
      else if (oneshot_done) ctl1_reg[RTPC_BIT_EN] <= 1'b0; // [R20]
      if (wr_ctl2) ctl2_reg <= {1'b0, wdata[6:5], 4'h0, wdata[0]};
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_reg <= RTPC_CNT_RST;
      rld_reg <= RTPC_RLD_RST;
      mat_reg <= RTPC_MAT_RST;
    end else begin
      cnt_reg <= cnt_next;
      mat_reg <= mat_next;
      if (wr_rldh) rld_reg[15:8] <= wdata; // [R6]
      if (wr_rldl) rld_reg[7:0] <= wdata;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mat_buf_reg <= RTPC_MAT_RST;
      mat_pend_reg <= 1'b0;
    end else begin
      if (ctl.buf_en && wr_math) mat_buf_reg[15:8] <= wdata;
      if (ctl.buf_en && wr_matl) mat_buf_reg[7:0] <= wdata;
      // a new buffered write wins over the apply
      if (ctl.buf_en && (wr_math || wr_matl)) mat_pend_reg <= 1'b1; // [R14]
      else if (mat_apply || cap_evt) mat_pend_reg <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cap_flag_reg <= 1'b0;
      timer_irq <= 1'b0;
    end else begin
      timer_irq <= irq_fire; // [R17]
      if (irq_fire) cap_flag_reg <= irq_from_input; // [R9]
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lvl_reg <= 1'b0;
      dly_cnt_reg <= 3'h0;
      timer_out <= 1'b0;
      timer_out_n <= 1'b0;
    end else begin
      lvl_reg <= lvl_next;
      if (m_pwm2 && lvl_chg) dly_cnt_reg <= ctl.dly; // [R10]
      else if (dly_cnt_reg != 3'h0) dly_cnt_reg <= dly_cnt_reg - 3'h1;
      timer_out <= dead ? ctl.pol : lvl_reg;
      timer_out_n <= dead ? ctl.pol : ~lvl_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  sequence s_oneshot_end;
    oneshot_done && !wr_ctl1 && !sw_cnt_wr;
  endsequence
  sequence s_pwm2_turn;
    m_pwm2 && ctl.en && lvl_chg && (ctl.dly != 3'h0) && !wr_ctl0 && !wr_ctl1;
  endsequence
  property p_reload_restart;
    (rld_evt && !sw_cnt_wr) |=> (cnt_reg == RTPC_CNT_RESTART);
  endproperty
  a_reload_restart: assert property (p_reload_restart) else $error("no restart at reload"); // [R5]
  property p_cmp_no_reload;
    (cmp_evt && !sw_cnt_wr) |=> (cnt_reg == 16'($past(cnt_reg) + 16'h0001))
      ##1 (timer_out != $past(timer_out));
  endproperty
  a_cmp_no_reload: assert property (p_cmp_no_reload) else $error("compare reloaded"); // [R6]
  property p_wrap;
    (count_tick && cnt_reg == RTPC_CNT_TOP && !rld_evt && !sw_cnt_wr && !cap_restart)
      |=> (cnt_reg == RTPC_CNT_WRAP);
  endproperty
  a_wrap: assert property (p_wrap) else $error("count did not wrap"); // [R19]
  property p_advance;
    (count_tick && !reload_hit && !sw_cnt_wr && !cap_restart)
      |=> (cnt_reg == 16'($past(cnt_reg) + 16'h0001));
  endproperty
  a_advance: assert property (p_advance) else $error("count did not advance"); // [R22]
  property p_hold;
    (!ctl.en && !sw_cnt_wr) [*2] |-> $stable(cnt_reg);
  endproperty
  a_hold: assert property (p_hold) else $error("count moved while disabled"); // [R22]
  property p_oneshot_stop;
    s_oneshot_end |=> !ctl.en && (cnt_reg == RTPC_CNT_RESTART) ##1 !pre_tick;
  endproperty
  a_oneshot_stop: assert property (p_oneshot_stop) else $error("one-shot kept running"); // [R20]
  property p_capture;
    cap_evt |=> (mat_reg == $past(cnt_reg));
  endproperty
  a_capture: assert property (p_capture) else $error("capture not stored"); // [R8]
  property p_cap_flag;
    (irq_fire && cap_evt && ctl.cause != RTPC_CAUSE_RLD_CMP) |=> cap_flag_reg && timer_irq;
  endproperty
  a_cap_flag: assert property (p_cap_flag) else $error("capture flag not set"); // [R9]
  property p_cause_filter;
    (ctl.cause == RTPC_CAUSE_RLD_CMP && !rld_evt && !cmp_evt) |=> !timer_irq;
  endproperty
  a_cause_filter: assert property (p_cause_filter) else $error("unexpected interrupt"); // [R17]
  property p_pwm_toggle;
    (match_hit && !reload_hit) |=> (lvl_reg != $past(lvl_reg));
  endproperty
  a_pwm_toggle: assert property (p_pwm_toggle) else $error("match did not toggle"); // [R7]
  property p_dead_time;
    s_pwm2_turn |=> ##1 (timer_out == $past(ctl.pol)) && (timer_out_n == $past(ctl.pol));
  endproperty
  a_dead_time: assert property (p_dead_time) else $error("dead time not kept"); // [R10]
  property p_buffered;
    (wr_matl && ctl.buf_en && !cap_evt && !mat_pend_reg) |=> $stable(mat_reg) && mat_pend_reg;
  endproperty
  a_buffered: assert property (p_buffered) else $error("buffered write applied early"); // [R14]
endmodule : rtpc_timer

//--- sim/rtpc_pin_model.sv
`timescale 1ns/1ns
module rtpc_pin_model (
  // system clock
  input wire logic hclk,
  // pins toward the timer
  output logic timer_in,
  output logic periph_clk
);
  initial begin
    timer_in = 1'b0;
    periph_clk = 1'b0;
  end

  // each level held w cycles; w >= 2 keeps the pin at a quarter clock or slower
  task automatic pulse(input int n, input int w);
    repeat (n) begin
      timer_in <= 1'b1;
      repeat (w) @(posedge hclk);
      timer_in <= 1'b0;
      repeat (w) @(posedge hclk);
    end
  endtask : pulse

  // peripheral clock runs only inside a burst, low otherwise
  task automatic clk_burst(input int n);
    repeat (n) begin
      periph_clk <= 1'b1;
      repeat (2) @(posedge hclk);
      periph_clk <= 1'b0;
      repeat (2) @(posedge hclk);
    end
  endtask : clk_burst
endmodule : rtpc_pin_model

//--- sim/tb_top.sv
`timescale 1ns/1ns
module tb_top import rtpc_pkg::*;;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic timer_in, periph_clk, timer_out, timer_out_n, timer_irq, out_q;
  int n_fail, comparisons, toggles, n_irq, n, k, n_eq;
  logic [31:0] seed;
  logic [7:0] q;
  logic [15:0] v, c;

  rtpc_timer u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .timer_in(timer_in),
    .periph_clk(periph_clk), .timer_out(timer_out), .timer_out_n(timer_out_n),
    .timer_irq(timer_irq));
  rtpc_pin_model u_pins (.hclk(hclk), .timer_in(timer_in), .periph_clk(periph_clk));

  always #20 hclk = ~hclk;

  // output edges and interrupt pulses seen
  always @(posedge hclk) begin
    out_q <= timer_out;
    if (hresetn && timer_out !== out_q) toggles++;
    if (timer_irq === 1'b1) n_irq++;
    if (hresetn && timer_out === timer_out_n) n_eq++;
  end

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  function automatic logic [7:0] ctl1_of(input logic en, input logic [2:0] e,
                                         input logic [3:0] m);
    return {en, 1'b0, e, m[2:0]};
  endfunction : ctl1_of

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one edge with hready sampled high, bounded
  task automatic ready_edge;
    int i;
    i = 0;
    do begin
      @(posedge hclk);
      i++;
    end while (hreadyout !== 1'b1 && i < 50);
    if (i >= 50) begin
      n_fail++;
      $display("Error at %0t: bus hang", $time);
      print_verdict();
    end
  endtask : ready_edge

  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
                     output logic [7:0] r);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'b10;
    hwrite <= w;
    ready_edge();
    htrans <= 2'b00;
    hwdata <= {24'h000000, d};
    ready_edge();
    r = hrdata[7:0];
    chk({15'h0000, hresp}, 16'h0000);
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] r;
    bus(1'b1, a, d, r);
  endtask : wr

  task automatic rd16(input logic [7:0] ah, input logic [7:0] al, output logic [15:0] r);
    bus(1'b0, ah, 8'h00, r[15:8]);
    bus(1'b0, al, 8'h00, r[7:0]);
  endtask : rd16

  task automatic wr16(input logic [7:0] ah, input logic [7:0] al, input logic [15:0] d);
    wr(ah, d[15:8]);
    wr(al, d[7:0]);
  endtask : wr16

  task automatic wait_irq(output int cyc);
    cyc = 0;
    do begin
      @(posedge hclk);
      cyc++;
    end while (timer_irq !== 1'b1 && cyc < 2000);
    if (cyc >= 2000) begin
      n_fail++;
      $display("Error at %0t: no interrupt", $time);
      print_verdict();
    end
  endtask : wait_irq

  task automatic setup(input logic [3:0] m, input logic [1:0] ca, input logic [2:0] e,
                       input logic [7:0] c2, input logic [15:0] cnt, input logic [15:0] rld);
    wr(RTPC_OFS_CTL1, ctl1_of(1'b0, e, m));
    wr(RTPC_OFS_CTL0, {m[3], ca, 5'h00});
    wr(RTPC_OFS_CTL2, c2);
    wr16(RTPC_OFS_CNTH, RTPC_OFS_CNTL, cnt);
    wr16(RTPC_OFS_RLDH, RTPC_OFS_RLDL, rld);
    wr(RTPC_OFS_CTL1, ctl1_of(1'b1, e, m));
  endtask : setup

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h00000000;
    n_fail = 0;
    comparisons = 0;
    toggles = 0;
    n_irq = 0;
    seed = 32'd85078;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd16(RTPC_OFS_CTL0, RTPC_OFS_CTL1, v);
    chk(v, {RTPC_CTL_RST, RTPC_CTL_RST});
    rd16(RTPC_OFS_CNTH, RTPC_OFS_CNTL, v);
    chk(v, RTPC_CNT_RST);
    rd16(RTPC_OFS_RLDH, RTPC_OFS_RLDL, v);
    chk(v, RTPC_RLD_RST);
    rd16(RTPC_OFS_MATH, RTPC_OFS_MATL, v);
    chk(v, RTPC_MAT_RST);
    wr(8'h24, 8'h5A);
    rd16(RTPC_OFS_CTL2, 8'h24, v);
    chk(v, 16'h0000);
    $display("test reset done");
    // every mode code lands in the split mode field
    for (int m = 0; m <= 10; m++) begin
      wr(RTPC_OFS_CTL0, {m[3], 7'h00});
      wr(RTPC_OFS_CTL1, ctl1_of(1'b0, 3'h0, m[3:0]));
      rd16(RTPC_OFS_CTL0, RTPC_OFS_CTL1, v);
      chk({12'h000, v[15], v[2:0]}, 16'(m));
    end
    seed = xs(seed);
    wr16(RTPC_OFS_CNTH, RTPC_OFS_CNTL, seed[15:0]);
    repeat (20) @(posedge hclk);
    rd16(RTPC_OFS_CNTH, RTPC_OFS_CNTL, v);
    chk(v, seed[15:0]);
    $display("test registers done");
    for (int e = 0; e < 8; e++) begin
      setup(RTPC_M_CONT, RTPC_CAUSE_ALL, e[2:0], 8'h00, 16'h0001, 16'h0003);
      wait_irq(n);
      wait_irq(n);
      chk(16'(n), 16'(3 << e));
      wr(RTPC_OFS_CTL1, 8'h00);
      rd16(RTPC_OFS_CTL0, RTPC_OFS_CTL0, v);
      chk({15'h0000, v[0]}, 16'h0000);
    end
    $display("test prescaler done");
    setup(RTPC_M_ONESHOT, RTPC_CAUSE_ALL, 3'h1, 8'h00, 16'h0001, 16'h0005);
    wait_irq(n);
    repeat (10) @(posedge hclk);
    rd16(RTPC_OFS_CTL1, RTPC_OFS_CNTL, v);
    chk({v[15], v[7:0]}, 16'h0001);
    setup(RTPC_M_CONT, RTPC_CAUSE_ALL, 3'h0, 8'h00, 16'hFFFE, 16'h0010);
    repeat (3) @(posedge hclk);
    wr(RTPC_OFS_CTL1, 8'h00);
    rd16(RTPC_OFS_CNTH, RTPC_OFS_CNTL, v);
    chk({15'h0000, v < 16'h0008}, 16'h0001);
    $display("test oneshot wrap done");
    for (int d = 0; d < 2; d++) begin
      seed = xs(seed);
      k = 1 + int'(seed[2:0]);
      setup(RTPC_M_COUNTER, RTPC_CAUSE_ALL, 3'h7, 8'(d << 5), 16'h0001, 16'hFFFF);
      u_pins.pulse(k, 2 + int'(seed[4:3]));
      repeat (8) @(posedge hclk);
      rd16(RTPC_OFS_CNTH, RTPC_OFS_CNTL, v);
      chk(v, 16'(1 + k * (d + 1)));
    end
    setup(RTPC_M_CONT, RTPC_CAUSE_ALL, 3'h0, 8'h01, 16'h0001, 16'hFFFF);
    u_pins.clk_burst(k);
    repeat (8) @(posedge hclk);
    rd16(RTPC_OFS_CNTH, RTPC_OFS_CNTL, v);
    chk(v, 16'(1 + k));
    $display("test pin counting done");
    setup(RTPC_M_CAP, RTPC_CAUSE_ALL, 3'h0, 8'h00, 16'h0001, 16'hFFFF);
    repeat (20) @(posedge hclk);
    fork
      u_pins.pulse(1, 3);
      wait_irq(n);
    join
    rd16(RTPC_OFS_MATH, RTPC_OFS_MATL, v);
    wr(RTPC_OFS_CTL1, 8'h00);
    rd16(RTPC_OFS_CNTH, RTPC_OFS_CNTL, c);
    chk({15'h0000, v > 16'h0010 && v < c}, 16'h0001);
    rd16(RTPC_OFS_CTL0, RTPC_OFS_CTL0, v);
    chk({15'h0000, v[0]}, 16'h0001);
    setup(RTPC_M_CAP, RTPC_CAUSE_RLD_CMP, 3'h0, 8'h00, 16'h0001, 16'hFFFF);
    n_irq = 0;
    u_pins.pulse(1, 3);
    repeat (20) @(posedge hclk);
    chk(16'(n_irq), 16'h0000);
    $display("test capture done");
    setup(RTPC_M_CMP, RTPC_CAUSE_ALL, 3'h0, 8'h00, 16'h0001, 16'h0008);
    wait_irq(n);
    chk({15'h0000, n < 20}, 16'h0001);
    wr16(RTPC_OFS_MATH, RTPC_OFS_MATL, 16'h0010);
    setup(RTPC_M_PWM1, RTPC_CAUSE_ALL, 3'h0, 8'h40, 16'h0001, 16'h0020);
    toggles = 0;
    n_eq = 0;
    repeat (100) @(posedge hclk);
    chk({15'h0000, toggles >= 4}, 16'h0001);
    chk(16'(n_eq), 16'h0000);
    wait_irq(n);
    wr(RTPC_OFS_MATL, 8'h18);
    rd16(RTPC_OFS_MATH, RTPC_OFS_MATL, v);
    chk(v, 16'h0010);
    wait_irq(n);
    rd16(RTPC_OFS_MATH, RTPC_OFS_MATL, v);
    chk(v, 16'h0018);
    setup(RTPC_M_PWM2, RTPC_CAUSE_ALL, 3'h0, 8'h00, 16'h0001, 16'h0020);
    wr(RTPC_OFS_CTL0, 8'h86);
    n_eq = 0;
    repeat (100) @(posedge hclk);
    chk({15'h0000, n_eq >= 6}, 16'h0001);
    $display("test compare pwm done");
    print_verdict();
  end
endmodule : tb_top
